// *** src/sdil_consts.svh ***
// Register indices, field positions, reset values and codes of the interrupt logic
`ifndef SDIL_CONSTS_SVH
`define SDIL_CONSTS_SVH

`define SDIL_IDX_SUMMARY   8'h02
`define SDIL_IDX_TX_CTRL   8'h08
`define SDIL_IDX_FLAGS     8'h0A
`define SDIL_IDX_MASK      8'h0B
`define SDIL_IDX_MODE      8'h0C

`define SDIL_BIT_XFER      0
`define SDIL_BIT_SLIP      1
`define SDIL_BIT_READY     4
`define SDIL_BIT_FASTER    5
`define SDIL_EVT_BITS      8'h33

`define SDIL_BIT_COPY_DIS  0
`define SDIL_BIT_SLIP_FRC  1
`define SDIL_CTRL_BITS     8'h03

`define SDIL_BIT_TX_SUM    0
`define SDIL_BIT_CONV_SUM  1

`define SDIL_MASK_RST      8'h00
`define SDIL_MODE_RST      8'h00
`define SDIL_FLAGS_RST     8'h00
`define SDIL_CTRL_RST      8'h00

`endif

// *** src/sdil_pkg.sv ***
// Types of the interrupt logic
package sdil_pkg;

  typedef enum logic [1:0]
  {
    SDIL_TRIG_RISE  = 2'h0,
    SDIL_TRIG_FALL  = 2'h1,
    SDIL_TRIG_LEVEL = 2'h2,
    SDIL_TRIG_RSVD  = 2'h3
  } sdil_trig_mode_t;

  typedef struct packed
  {
    logic prev;
  } sdil_trig_state_t;

  typedef struct packed
  {
    logic [7:0]  mask;
    logic [7:0]  mode;
    logic [7:0]  flags;
    logic [7:0]  ctrl;
    logic [31:0] prdata;
  } sdil_state_t;

endpackage

// *** src/sdil_trig_if.sv ***
// Carrier between an event source and its trigger detector
`timescale 1ns/1ps
interface sdil_trig_if;
  import sdil_pkg::*;

  logic            src_level;
  sdil_trig_mode_t mode;
  logic            hit;

  modport det (input src_level, input mode, output hit);
  modport ctl (output src_level, output mode, input hit);
endinterface

// *** src/sdil_trigger.sv ***
// Trigger detector for one event: rising, falling or level
`timescale 1ns/1ps
module sdil_trigger
  import sdil_pkg::*;
(
  input  logic       pclk,
  input  logic       presetn,
  sdil_trig_if.det   port
);

  sdil_trig_state_t st_reg;
  sdil_trig_state_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.prev = port.src_level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Mode decode, reserved code never fires
  always_comb
  begin
    case (port.mode)
      SDIL_TRIG_RISE:  port.hit = port.src_level & ~st_reg.prev; // RULE_12
      SDIL_TRIG_FALL:  port.hit = ~port.src_level & st_reg.prev; // RULE_12
      SDIL_TRIG_LEVEL: port.hit = port.src_level;                // RULE_13
      default:         port.hit = 1'b0;
    endcase
  end

  property p_rise_edge;
    @(posedge pclk) disable iff (!presetn)
    (port.mode == SDIL_TRIG_RISE)
      |-> (port.hit == (port.src_level && !($past(port.src_level) && $past(presetn))));
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising trigger mismatch"); // RULE_12

  property p_fall_edge;
    @(posedge pclk) disable iff (!presetn)
    (port.mode == SDIL_TRIG_FALL)
      |-> (port.hit == (!port.src_level && $past(port.src_level) && $past(presetn)));
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling trigger mismatch"); // RULE_13

  property p_reserved_quiet;
    @(posedge pclk) disable iff (!presetn)
    (port.mode == SDIL_TRIG_RSVD) |-> !port.hit;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved mode fired"); // RULE_12

endmodule

// *** src/sdil_top.sv ***
// Interrupt logic of the rate converter and transmitter with APB registers
//
// Summary of operation
// RULE_01: Enabled buffer copy sets transfer flag
// RULE_02: Unmasked transfer flag drives irq and summary
// RULE_03: Slip or block start sets slip flag
// RULE_04: Forced block start slip acts as slip
// RULE_05: Unmasked transmitter event sets transmitter summary
// RULE_06: Both estimators done sets estimator flag
// RULE_07: Input faster than output sets direction flag
// RULE_08: Unmasked converter event drives irq and summary
// RULE_09: Mask bits at 5, 4, 1, 0
// RULE_10: Mask zero blocks, one enables, reset zero
// RULE_11: Mode fields at 7:6, 5:4, 3:2, 1:0
// RULE_12: Transmitter modes: rise, fall, level, reserved
// RULE_13: Converter modes use same encoding
// RULE_14: Unused bits read zero, ignore writes
`timescale 1ns/1ps
`include "sdil_consts.svh"
module sdil_top
  import sdil_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  logic              pclk,
  input  logic              presetn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [ADDR_W-1:0] paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic              tx_xfer_event,
  input  logic              tx_slip_detect,
  input  logic              estimators_done,
  input  logic              input_faster,
  output logic              irq_n,
  output logic              tx_buffer_copy_disable,
  output logic              block_start_slip_force
);

  sdil_state_t       st_reg;
  sdil_state_t       st_next;
  logic [3:0]        evt_src;
  logic [3:0]        evt_hit;
  logic [7:0]        evt_set;
  logic [7:0]        pend;
  logic              tx_summary;
  logic              conv_summary;
  logic [ADDR_W-3:0] word;
  logic              addr_ok;
  logic              wr_acc;
  logic              rd_setup;

  // Event sources
  assign evt_src[0] = tx_xfer_event & ~st_reg.ctrl[`SDIL_BIT_COPY_DIS]; // RULE_01
  assign evt_src[1] = tx_slip_detect | st_reg.ctrl[`SDIL_BIT_SLIP_FRC]; // RULE_03 RULE_04
  assign evt_src[2] = estimators_done;                                  // RULE_06
  assign evt_src[3] = input_faster;                                     // RULE_07

  // One trigger detector per event, mode field 2i+1:2i
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_evt
      sdil_trig_if u_if ();
      assign u_if.src_level = evt_src[gi];
      assign u_if.mode      = sdil_trig_mode_t'(st_reg.mode[2*gi +: 2]); // RULE_11
      assign evt_hit[gi]    = u_if.hit;
      sdil_trigger u_trig
      (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (u_if.det)
      );
    end
  endgenerate

  // Place the hits at their flag positions
  assign evt_set = {2'b00, evt_hit[3], evt_hit[2], 2'b00, evt_hit[1], evt_hit[0]}; // RULE_09

  assign pend         = st_reg.flags & st_reg.mask;                                     // RULE_10
  assign tx_summary   = pend[`SDIL_BIT_XFER] | pend[`SDIL_BIT_SLIP];                    // RULE_05
  assign conv_summary = pend[`SDIL_BIT_READY] | pend[`SDIL_BIT_FASTER];                 // RULE_08
  assign irq_n        = ~(tx_summary | conv_summary);                                   // RULE_02 RULE_08

  // Bus decode
  assign word     = paddr[ADDR_W-1:2];
  assign wr_acc   = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb
  begin
    addr_ok = 1'b0;
    if (paddr[1:0] == 2'h0)
    begin
      case (word)
        (ADDR_W-2)'(`SDIL_IDX_SUMMARY): addr_ok = 1'b1;
        (ADDR_W-2)'(`SDIL_IDX_TX_CTRL): addr_ok = 1'b1;
        (ADDR_W-2)'(`SDIL_IDX_FLAGS):   addr_ok = 1'b1;
        (ADDR_W-2)'(`SDIL_IDX_MASK):    addr_ok = 1'b1;
        (ADDR_W-2)'(`SDIL_IDX_MODE):    addr_ok = 1'b1;
        default:                        addr_ok = 1'b0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = st_reg.prdata;

  assign tx_buffer_copy_disable = st_reg.ctrl[`SDIL_BIT_COPY_DIS];
  assign block_start_slip_force = st_reg.ctrl[`SDIL_BIT_SLIP_FRC];

  always_comb
  begin
    st_next = st_reg;
    // Flags are sticky; a new event wins over a write-one clear
    if (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_FLAGS))
    begin
      st_next.flags = st_reg.flags & ~(pwdata[7:0] & `SDIL_EVT_BITS);
    end
    st_next.flags = st_next.flags | (evt_set & st_reg.mask); // RULE_01 RULE_03 RULE_06 RULE_07
    if (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_MASK))
    begin
      st_next.mask = pwdata[7:0] & `SDIL_EVT_BITS; // RULE_09 RULE_14
    end
    if (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_MODE))
    begin
      st_next.mode = pwdata[7:0]; // RULE_11
    end
    if (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_TX_CTRL))
    begin
      st_next.ctrl = pwdata[7:0] & `SDIL_CTRL_BITS; // RULE_14
    end
    // Read data is captured in the setup cycle
    if (rd_setup)
    begin
      st_next.prdata = 32'h0000_0000;
      if (paddr[1:0] == 2'h0)
      begin
        case (word)
          (ADDR_W-2)'(`SDIL_IDX_SUMMARY):
          begin
            st_next.prdata[`SDIL_BIT_TX_SUM]   = tx_summary;   // RULE_05
            st_next.prdata[`SDIL_BIT_CONV_SUM] = conv_summary; // RULE_08
          end
          (ADDR_W-2)'(`SDIL_IDX_TX_CTRL):
          begin
            st_next.prdata[7:0] = st_reg.ctrl;
          end
          (ADDR_W-2)'(`SDIL_IDX_FLAGS):
          begin
            st_next.prdata[7:0] = st_reg.flags;
          end
          (ADDR_W-2)'(`SDIL_IDX_MASK):
          begin
            st_next.prdata[7:0] = st_reg.mask;
          end
          (ADDR_W-2)'(`SDIL_IDX_MODE):
          begin
            st_next.prdata[7:0] = st_reg.mode;
          end
          default:
          begin
            st_next.prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg.mask   <= `SDIL_MASK_RST; // RULE_10
      st_reg.mode   <= `SDIL_MODE_RST; // RULE_12
      st_reg.flags  <= `SDIL_FLAGS_RST;
      st_reg.ctrl   <= `SDIL_CTRL_RST;
      st_reg.prdata <= 32'h0000_0000;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  property p_xfer_sets;
    @(posedge pclk) disable iff (!presetn)
    (evt_hit[0] && st_reg.mask[`SDIL_BIT_XFER]) |=> st_reg.flags[`SDIL_BIT_XFER];
  endproperty
  a_xfer_sets: assert property (p_xfer_sets) else $error("transfer flag not set"); // RULE_01

  property p_copy_disable;
    @(posedge pclk) disable iff (!presetn)
    st_reg.ctrl[`SDIL_BIT_COPY_DIS] |-> !evt_src[0];
  endproperty
  a_copy_disable: assert property (p_copy_disable) else $error("disabled copy raised event"); // RULE_01

  property p_xfer_irq;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.flags[`SDIL_BIT_XFER] && st_reg.mask[`SDIL_BIT_XFER]) |-> (!irq_n && tx_summary);
  endproperty
  a_xfer_irq: assert property (p_xfer_irq) else $error("transfer irq missing"); // RULE_02

  property p_slip_sets;
    @(posedge pclk) disable iff (!presetn)
    (evt_hit[1] && st_reg.mask[`SDIL_BIT_SLIP]) |=> st_reg.flags[`SDIL_BIT_SLIP];
  endproperty
  a_slip_sets: assert property (p_slip_sets) else $error("slip flag not set"); // RULE_03

  property p_force_irq;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.ctrl[`SDIL_BIT_SLIP_FRC] && st_reg.mode[3:2] == SDIL_TRIG_LEVEL
      && st_reg.mask[`SDIL_BIT_SLIP] && !(wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_MASK))) |=> !irq_n;
  endproperty
  a_force_irq: assert property (p_force_irq) else $error("forced slip gave no irq"); // RULE_04

  property p_tx_summary;
    @(posedge pclk) disable iff (!presetn)
    tx_summary == (|(st_reg.flags[1:0] & st_reg.mask[1:0]));
  endproperty
  a_tx_summary: assert property (p_tx_summary) else $error("tx summary wrong"); // RULE_05

  property p_ready_sets;
    @(posedge pclk) disable iff (!presetn)
    (evt_hit[2] && st_reg.mask[`SDIL_BIT_READY]) |=> st_reg.flags[`SDIL_BIT_READY];
  endproperty
  a_ready_sets: assert property (p_ready_sets) else $error("estimator flag not set"); // RULE_06

  property p_faster_sets;
    @(posedge pclk) disable iff (!presetn)
    (evt_hit[3] && st_reg.mask[`SDIL_BIT_FASTER]) |=> st_reg.flags[`SDIL_BIT_FASTER];
  endproperty
  a_faster_sets: assert property (p_faster_sets) else $error("direction flag not set"); // RULE_07

  property p_conv_irq;
    @(posedge pclk) disable iff (!presetn)
    (|(st_reg.flags[5:4] & st_reg.mask[5:4])) |-> (!irq_n && conv_summary);
  endproperty
  a_conv_irq: assert property (p_conv_irq) else $error("converter irq missing"); // RULE_08

  property p_mask_layout;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.mask & ~`SDIL_EVT_BITS) == 8'h00;
  endproperty
  a_mask_layout: assert property (p_mask_layout) else $error("mask reserved bit set"); // RULE_09

  property p_masked_no_set;
    @(posedge pclk) disable iff (!presetn)
    $rose(st_reg.flags[`SDIL_BIT_READY]) |-> $past(st_reg.mask[`SDIL_BIT_READY]);
  endproperty
  a_masked_no_set: assert property (p_masked_no_set) else $error("masked event set flag"); // RULE_10

  property p_mode_store;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_MODE)) |=> st_reg.mode == $past(pwdata[7:0]);
  endproperty
  a_mode_store: assert property (p_mode_store) else $error("mode write lost"); // RULE_11

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    ((st_reg.flags & ~`SDIL_EVT_BITS) == 8'h00) && ((st_reg.ctrl & ~`SDIL_CTRL_BITS) == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set"); // RULE_14

  property p_set_beats_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_FLAGS) && evt_hit[0] && st_reg.mask[0])
      |=> st_reg.flags[`SDIL_BIT_XFER];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost on clear"); // RULE_01

  property p_slip_irq;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.flags[`SDIL_BIT_SLIP] && st_reg.mask[`SDIL_BIT_SLIP]) |-> (!irq_n && tx_summary);
  endproperty
  a_slip_irq: assert property (p_slip_irq) else $error("slip irq missing"); // RULE_04

  property p_irq_idle;
    @(posedge pclk) disable iff (!presetn)
    ((st_reg.flags & st_reg.mask) == 8'h00) |-> irq_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq without pending event"); // RULE_10

  property p_mask_store;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_MASK))
      |=> st_reg.mask == ($past(pwdata[7:0]) & `SDIL_EVT_BITS);
  endproperty
  a_mask_store: assert property (p_mask_store) else $error("mask write lost"); // RULE_09

  property p_ctrl_store;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_TX_CTRL))
      |=> st_reg.ctrl == ($past(pwdata[7:0]) & `SDIL_CTRL_BITS);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control write lost"); // RULE_14

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_FLAGS) && pwdata[`SDIL_BIT_READY]
      && !(evt_hit[2] && st_reg.mask[`SDIL_BIT_READY])) |=> !st_reg.flags[`SDIL_BIT_READY];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("estimator flag not cleared"); // RULE_06

  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.flags[`SDIL_BIT_FASTER] && !(wr_acc && word == (ADDR_W-2)'(`SDIL_IDX_FLAGS)))
      |=> st_reg.flags[`SDIL_BIT_FASTER];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("direction flag dropped"); // RULE_07

  property p_masked_xfer;
    @(posedge pclk) disable iff (!presetn)
    $rose(st_reg.flags[`SDIL_BIT_XFER]) |-> $past(st_reg.mask[`SDIL_BIT_XFER]);
  endproperty
  a_masked_xfer: assert property (p_masked_xfer) else $error("masked transfer set flag"); // RULE_10

  property p_read_flags;
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr[1:0] == 2'h0 && word == (ADDR_W-2)'(`SDIL_IDX_FLAGS))
      |=> prdata == {24'h000000, $past(st_reg.flags)};
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flags read wrong"); // RULE_14

  property p_read_summary;
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr[1:0] == 2'h0 && word == (ADDR_W-2)'(`SDIL_IDX_SUMMARY))
      |=> prdata == {30'h00000000, $past(conv_summary), $past(tx_summary)};
  endproperty
  a_read_summary: assert property (p_read_summary) else $error("summary read wrong"); // RULE_05

  property p_read_mode;
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr[1:0] == 2'h0 && word == (ADDR_W-2)'(`SDIL_IDX_MODE))
      |=> prdata == {24'h000000, $past(st_reg.mode)};
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("mode read wrong"); // RULE_11

  property p_bad_addr_ignored;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !addr_ok)
      |=> ($stable(st_reg.mask) && $stable(st_reg.mode) && $stable(st_reg.ctrl));
  endproperty
  a_bad_addr_ignored: assert property (p_bad_addr_ignored) else $error("unmapped write landed"); // RULE_14

endmodule

// *** test/sdil_host_model.sv ***
// Host model that watches the interrupt output
`timescale 1ns/1ps
module sdil_host_model
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic irq_n,
  output int        irq_cycles
);
  // Counts the cycles in which the device asks for service
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_cycles <= 0;
    else if (irq_n === 1'b0)
      irq_cycles <= irq_cycles + 1;
  end
endmodule

// *** test/tb_sdil_top.sv ***
// Self-checking testbench of the interrupt logic with a behavioural model
`timescale 1ns/1ps
module tb_sdil_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq_n, copy_dis, slip_frc, rand_on;
  logic [3:0]  ev = 4'h0;
  logic [3:0]  src, m_prev;
  logic [7:0]  m_mask, m_mode, m_flags, m_ctrl, nf;
  logic [7:0]  lf = 8'h4A;
  logic [11:0] regs [5] = '{12'h008, 12'h020, 12'h028, 12'h02C, 12'h030};
  int          miscompares, check_count, m_irq_cyc, irq_cycles;

  sdil_top #(.ADDR_W(12)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_xfer_event(ev[0]), .tx_slip_detect(ev[1]), .estimators_done(ev[2]),
    .input_faster(ev[3]), .irq_n(irq_n), .tx_buffer_copy_disable(copy_dis),
    .block_start_slip_force(slip_frc));
  sdil_host_model u_host (.pclk(pclk), .presetn(presetn), .irq_n(irq_n), .irq_cycles(irq_cycles));

  function automatic logic [7:0] lfsr(logic [7:0] x);
    lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic trig(logic [1:0] md, logic s, logic p);
    case (md)
      2'h0: trig = s & ~p;
      2'h1: trig = ~s & p;
      2'h2: trig = s;
      default: trig = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] mread(logic [11:0] a);
    case (a)
      12'h008: mread = {30'h0, |(m_flags & m_mask & 8'h30), |(m_flags & m_mask & 8'h03)};
      12'h020: mread = {24'h0, m_ctrl};
      12'h028: mread = {24'h0, m_flags};
      12'h02C: mread = {24'h0, m_mask};
      12'h030: mread = {24'h0, m_mode};
      default: mread = 32'h0;
    endcase
  endfunction

  // Event sources as the detectors see them
  assign src = {ev[3], ev[2], ev[1] | m_ctrl[1], ev[0] & ~m_ctrl[0]};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {m_mask, m_mode, m_flags, m_ctrl, m_prev} <= '0;
      m_irq_cyc <= 0;
    end
    else
    begin
      if (|(m_flags & m_mask))
        m_irq_cyc <= m_irq_cyc + 1;
      m_prev <= src;
      nf = m_flags;
      if (psel && penable && pwrite)
      begin
        if (paddr == 12'h02C) m_mask <= pwdata[7:0] & 8'h33;
        if (paddr == 12'h030) m_mode <= pwdata[7:0];
        if (paddr == 12'h020) m_ctrl <= pwdata[7:0] & 8'h03;
        if (paddr == 12'h028) nf = nf & ~pwdata[7:0];
      end
      for (int i = 0; i < 4; i++)
        if (trig(m_mode[2*i +: 2], src[i], m_prev[i]) && m_mask[i < 2 ? i : i + 2])
          nf[i < 2 ? i : i + 2] = 1'b1;
      m_flags <= nf;
    end
  end

  always @(posedge pclk)
  begin
    lf <= lfsr(lf);
    if (rand_on)
      ev <= lf[3:0];
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [31:0] exp;
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(negedge pclk);
    exp = mread(a);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
    if (!w) check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, !(a inside {regs})});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(negedge pclk)
  begin
    if (presetn)
    begin
      check({31'h0, irq_n}, {31'h0, ~|(m_flags & m_mask)});
      check({30'h0, slip_frc, copy_dis}, {30'h0, m_ctrl[1:0]});
    end
  end

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial
  begin
    #100000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, rand_on} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) apb(1'b0, regs[i], 8'h00);
    for (int i = 0; i < 5; i++) apb(1'b1, regs[i], 8'hFF);
    for (int i = 0; i < 5; i++) apb(1'b0, regs[i], 8'h00);
    apb(1'b1, 12'h03C, 8'hFF);
    apb(1'b0, 12'h03C, 8'h00);
    apb(1'b0, 12'h02D, 8'h00);
    rand_on <= 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      apb(1'b1, 12'h030, {4{k[1:0]}});
      apb(1'b1, 12'h020, {6'h0, k[3:2]});
      apb(1'b1, 12'h02C, (k % 3 == 2) ? 8'h00 : (k % 3 == 1) ? lf : 8'h33);
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h028, 8'h00);
      apb(1'b0, 12'h008, 8'h00);
      apb(1'b1, 12'h028, 8'hFF);
      apb(1'b0, 12'h028, 8'h00);
    end
    rand_on <= 1'b0;
    @(posedge pclk);
    check(irq_cycles, m_irq_cyc);
    complete_run();
  end
endmodule
